/* lcrc_cell.sv */
// shared constants of the logic cell register control, and one counter-mode register cell
// assumes one clock clk_i; the caller resolves the async control of each cell
`timescale 1ns/100ps

package lcrc_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int CNT_W = 8;                     // cells in the logic_array_block
    localparam int MEM_W = 16;                    // embedded_memory_block register width
    localparam int ADR_W = 8;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] ADR_CTRL   = 8'h00;
    localparam logic [ADR_W-1:0] ADR_LOAD   = 8'h04;
    localparam logic [ADR_W-1:0] ADR_CMD    = 8'h08;
    localparam logic [ADR_W-1:0] ADR_ADDEND = 8'h0c;
    localparam logic [ADR_W-1:0] ADR_COUNT  = 8'h10;
    localparam logic [ADR_W-1:0] ADR_COMB   = 8'h14;
    localparam logic [ADR_W-1:0] ADR_STATUS = 8'h18;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_MODE  = 0;                // 1 counter, 0 arithmetic
    localparam int CTRL_CASC  = 1;                // cascade chain in use
    localparam int CTRL_CHIPEN = 2;               // chip-wide reset honoured
    localparam int CTRL_CNTEN = 3;                // datapath advances
    localparam int CTRL_W     = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h5;
    localparam int CMD_SCLR   = 0;
    localparam int CMD_SLOAD  = 1;
    localparam int STAT_CARRY = 0;
    localparam int STAT_UNK   = 1;
    localparam int STAT_IO    = 2;

    typedef enum logic [0:0] {
        LCRC_MODE_ARITH = 1'b0,
        LCRC_MODE_COUNT = 1'b1
    } lcrc_mode_e;
endpackage : lcrc_pkg

module lcrc_cell
    import lcrc_pkg::*;
#(
    parameter bit PRESET = 1'b0                   // 1: async control presets the cell
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // async control, already resolved
    input  wire logic async_i,
    // synchronous controls
    input  wire logic sclr_i,
    input  wire logic sload_i,
    input  wire logic load_d_i,
    input  wire logic upd_i,
    // datapath
    input  wire logic b_i,
    input  wire logic carry_i,
    input  wire logic casc_en_i,
    input  wire logic casc_i,
    output logic      q_o,
    output logic      sum_o,
    output logic      carry_o
);
    logic data_d;
    logic casc_d;
    logic sel_d;
    logic next_q;

    // two 3-input lookup tables: data and fast carry
    assign sum_o   = q_o ^ b_i ^ carry_i;
    assign carry_o = (q_o & b_i) | (q_o & carry_i) | (b_i & carry_i);

    // load mux and clear gate sit after the cascade, so both beat it
    assign data_d = upd_i ? sum_o : q_o;
    assign casc_d = casc_en_i ? (data_d & casc_i) : data_d;
    assign sel_d  = sload_i ? load_d_i : casc_d;
    assign next_q = sel_d & ~sclr_i;

    // async control first, then sync reset, then data
    if (PRESET) begin : g_preset
        // preset cell: inverted cleared register, so it sets
        always_ff @(posedge clk_i or posedge async_i) begin
            if (async_i) begin
                q_o <= 1'b1;
            end else if (rst_i) begin
                q_o <= 1'b1;
            end else begin
                q_o <= next_q;
            end
        end
    end else begin : g_clear
        always_ff @(posedge clk_i or posedge async_i) begin
            if (async_i) begin
                q_o <= 1'b0;
            end else if (rst_i) begin
                q_o <= 1'b0;
            end else begin
                q_o <= next_q;
            end
        end
    end
endmodule : lcrc_cell

/* lcrc_register_control.sv */
// logic cell register control: a logic_array_block of counter cells, an io_element
// register and the embedded_memory_block registers, configured over classic Wishbone
// assumes one clock; async control ports change only just after a rising clock edge
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps

module lcrc_register_control
    import lcrc_pkg::*;
#(
    parameter int                W           = CNT_W,
    parameter int                MW          = MEM_W,
    parameter logic [CNT_W-1:0]  PRESET_MASK = 8'h00, // cells built as preset registers
    parameter bit                EMULATED    = 1'b0,  // block holds emulated preset+load
    parameter bit                IO_PWR_HIGH = 1'b0   // io_element power-up value
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // shared async controls
    input  wire logic              chip_wide_reset_n_i,
    input  wire logic              logic_array_block_clear_i,
    input  wire logic              logic_array_block_preset_i,
    // logic_array_block datapath
    input  wire logic [W-1:0]      cascade_i,
    output logic      [W-1:0]      count_o,
    // io_element register
    input  wire logic              config_done_i,
    input  wire logic              io_d_i,
    input  wire logic              io_clear_i,
    input  wire logic              io_preset_i,
    output logic                   io_q_o,
    // embedded_memory_block registers
    input  wire logic              mem_local_clear_i,
    input  wire logic              mem_global_clear_i,
    input  wire logic [MW-1:0]     mem_in_d_i,
    input  wire logic [MW-1:0]     mem_out_d_i,
    output logic      [MW-1:0]     mem_in_q_o,
    output logic      [MW-1:0]     mem_out_q_o
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [W-1:0]      load_val;
    logic [W-1:0]      addend;
    logic              unknown;
    logic              req;
    logic              wr;
    logic [W-1:0]      wmask;
    logic [W-1:0]      next_load;
    logic [W-1:0]      next_addend;
    logic [31:0]       rd_data;
    logic              sclr;
    logic              sload;
    lcrc_mode_e        mode;
    logic              chip_aclr;
    logic              async_any;
    logic [W-1:0]      sum;
    logic [W:0]        carry;
    logic              mem_aclr;
    logic              io_aclr;
    logic [2:0]        status;

    // answer one cycle after the request; effect at the acknowledging edge
    assign req = wb_cyc_i & wb_stb_i;
    assign wr  = req & wb_we_i & wb_ack_o;

    // byte lanes steer the wide registers bit by bit
    for (genvar i = 0; i < W; i++) begin : g_lane
        assign wmask[i] = wb_sel_i[i / 8];
    end
    assign next_load   = (load_val & ~wmask) | (wb_dat_i[W-1:0] & wmask);
    assign next_addend = (addend & ~wmask) | (wb_dat_i[W-1:0] & wmask);

    // command bits act for one cycle only and read back as zero
    assign sclr  = wr & (wb_adr_i == ADR_CMD) & wb_sel_i[0] & wb_dat_i[CMD_SCLR];
    assign sload = wr & (wb_adr_i == ADR_CMD) & wb_sel_i[0] & wb_dat_i[CMD_SLOAD];
    assign mode  = lcrc_mode_e'(ctrl[CTRL_MODE]);

    assign status = {io_q_o, unknown, carry[W]};
    // comb reads the live table result, the unregistered twin of count
    assign rd_data = (wb_adr_i == ADR_CTRL)   ? 32'(ctrl)     :
                     (wb_adr_i == ADR_LOAD)   ? 32'(load_val) :
                     (wb_adr_i == ADR_ADDEND) ? 32'(addend)   :
                     (wb_adr_i == ADR_COUNT)  ? 32'(count_o)  :
                     (wb_adr_i == ADR_COMB)   ? 32'(sum)      :
                     (wb_adr_i == ADR_STATUS) ? 32'(status)   : 32'h0;

    // ack pulses for one cycle; unmapped addresses still answer, reading zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= rd_data;
        end
    end

    // software registers; bus config is not touched by the chip-wide reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= CTRL_RST;
            load_val <= '0;
            addend   <= '0;
        end else if (wr) begin
            if (wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
                ctrl <= wb_dat_i[CTRL_W-1:0];
            end
            if (wb_adr_i == ADR_LOAD) begin
                load_val <= next_load;
            end
            if (wb_adr_i == ADR_ADDEND) begin
                addend <= next_addend;
            end
        end
    end

    // ------------------------------------------------------------
    // logic_array_block cells
    // ------------------------------------------------------------
    // chip-wide reset only when enabled; it joins every async control
    assign chip_aclr = ctrl[CTRL_CHIPEN] & ~chip_wide_reset_n_i;
    assign async_any = chip_aclr | logic_array_block_clear_i | logic_array_block_preset_i;

    // counter adds one through the carry; arithmetic adds the addend
    assign carry[0] = (mode == LCRC_MODE_COUNT);

    for (genvar i = 0; i < W; i++) begin : g_cell
        logic cell_async;
        logic cell_b;
        // one shared clear or preset per block, chosen by how the cell is built
        assign cell_async = PRESET_MASK[i] ?
                            (chip_aclr | logic_array_block_preset_i) :
                            (chip_aclr | logic_array_block_clear_i);
        assign cell_b = (mode == LCRC_MODE_ARITH) & addend[i];
        lcrc_cell #(
            .PRESET    (PRESET_MASK[i])
        ) u_cell (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .async_i   (cell_async),
            .sclr_i    (sclr),
            .sload_i   (sload),
            .load_d_i  (load_val[i]),
            .upd_i     (ctrl[CTRL_CNTEN]),
            .b_i       (cell_b),
            .carry_i   (carry[i]),
            .casc_en_i (ctrl[CTRL_CASC]),
            .casc_i    (cascade_i[i]),
            .q_o       (count_o[i]),
            .sum_o     (sum[i]),
            .carry_o   (carry[i+1])
        );
    end

    // emulated preset+load registers are unknown after power-up or a chip reset, until loaded;
    // the chip reset sets the flag even when a load lands in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unknown <= EMULATED;
        end else if (EMULATED && chip_aclr) begin
            unknown <= 1'b1;
        end else if (sload) begin
            unknown <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // io_element register
    // ------------------------------------------------------------
    // low power-up pairs with clear, high with preset
    assign io_aclr = chip_aclr | (IO_PWR_HIGH ? io_preset_i : io_clear_i);

    if (IO_PWR_HIGH) begin : g_io_high
        always_ff @(posedge clk_i or posedge io_aclr) begin
            if (io_aclr) begin
                io_q_o <= 1'b1;
            end else if (rst_i || !config_done_i) begin
                io_q_o <= 1'b1;
            end else begin
                io_q_o <= io_d_i;
            end
        end
    end else begin : g_io_low
        always_ff @(posedge clk_i or posedge io_aclr) begin
            if (io_aclr) begin
                io_q_o <= 1'b0;
            end else if (rst_i || !config_done_i) begin
                io_q_o <= 1'b0;
            end else begin
                io_q_o <= io_d_i;
            end
        end
    end

    // ------------------------------------------------------------
    // embedded_memory_block registers
    // ------------------------------------------------------------
    assign mem_aclr = mem_local_clear_i | mem_global_clear_i | chip_aclr;

    // input and output registers share one clear
    always_ff @(posedge clk_i or posedge mem_aclr) begin
        if (mem_aclr) begin
            mem_in_q_o  <= '0;
            mem_out_q_o <= '0;
        end else if (rst_i) begin
            mem_in_q_o  <= '0;
            mem_out_q_o <= '0;
        end else begin
            mem_in_q_o  <= mem_in_d_i;
            mem_out_q_o <= mem_out_d_i;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_quiet;
        !async_any && !sclr && !sload;
    endsequence

    sequence s_both_ctl;
        sclr && sload && !async_any;
    endsequence

    a_sclr_over_load: assert property (
        s_both_ctl |=> (async_any || count_o == '0))
        else $error("sync clear did not win over sync load");

    a_load_value: assert property (
        (sload && !sclr && !async_any) |=> (async_any || count_o == $past(load_val)))
        else $error("sync load value not taken over cascade");

    a_count_step: assert property (
        (s_quiet and (mode == LCRC_MODE_COUNT && ctrl[CTRL_CNTEN] && !ctrl[CTRL_CASC]))
        |=> (async_any || count_o == W'($past(count_o) + 1'b1)))
        else $error("counter did not step by one");

    a_arith_pair: assert property (
        (s_quiet and (mode == LCRC_MODE_ARITH && ctrl[CTRL_CNTEN] && !ctrl[CTRL_CASC]))
        |=> (async_any || count_o == $past(sum)))
        else $error("registered result differs from table result");

    a_block_clear: assert property (
        logic_array_block_clear_i |-> (count_o & ~PRESET_MASK) == '0)
        else $error("block clear did not zero clear cells at once");

    a_chip_reset: assert property (
        (chip_aclr && !logic_array_block_clear_i) |->
        (count_o == PRESET_MASK && mem_in_q_o == '0 && io_q_o == IO_PWR_HIGH))
        else $error("chip reset did not force registers");

    a_unknown_flag: assert property (
        chip_aclr |=> (unknown == EMULATED) [*2])
        else $error("unknown flag not tracking chip reset");

    a_io_powerup: assert property (
        (!config_done_i && !io_aclr) |=> (io_aclr || io_q_o == IO_PWR_HIGH))
        else $error("io register left power-up value early");

    a_io_async: assert property (
        (IO_PWR_HIGH ? io_clear_i : io_preset_i) && !io_aclr && config_done_i
        |=> (io_aclr || io_q_o == $past(io_d_i)))
        else $error("io register took the wrong async control");

    a_mem_clear: assert property (
        mem_aclr |-> (mem_in_q_o == '0 && mem_out_q_o == '0))
        else $error("memory registers not cleared");

    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
endmodule : lcrc_register_control

/* lcrc_register_control_test.sv */
// testbench of the logic cell register control: wishbone tasks, one task per scenario
// assumes the design files are compiled first; async controls move just after a clock edge
`timescale 1ns/100ps

`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end

module lcrc_register_control_test;
    import lcrc_pkg::*;

    // ------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------
    localparam logic [7:0]  PMASK = 8'h0f;              // cells 0..3 built as preset registers
    localparam logic [31:0] C_SLD = 32'h1 << CMD_SLOAD;
    localparam logic [31:0] C_CLR = 32'h1 << CMD_SCLR;
    localparam logic [31:0] K_CNT = 32'h1 << CTRL_MODE;
    localparam logic [31:0] K_CAS = 32'h1 << CTRL_CASC;
    localparam logic [31:0] K_CHP = 32'h1 << CTRL_CHIPEN;
    localparam logic [31:0] K_RUN = 32'h1 << CTRL_CNTEN;

    logic        clk_i = 1'h0, rst_i = 1'h1;
    logic        cyc = 1'h0, we = 1'h0, ack;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic        chip_n = 1'h1, blk_clr = 1'h0, blk_pre = 1'h0;
    logic [7:0]  casc = 8'hff, cnt;
    logic        cfg_done = 1'h0, io_d = 1'h1, io_clr = 1'h0, io_pre = 1'h0, io_q;
    logic        mem_lclr = 1'h0, mem_gclr = 1'h0;
    logic [15:0] mem_in = 16'h0, mem_out = 16'h0, mem_in_q, mem_out_q;
    int          error_cnt = 0;
    int          comparisons = 0;

    // half period of a 25 MHz clock
    always #20 clk_i = ~clk_i;

    // cyc doubles as stb: a classic master raises and drops them together
    lcrc_register_control #(.PRESET_MASK(PMASK), .EMULATED(1'h1), .IO_PWR_HIGH(1'h0)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .chip_wide_reset_n_i(chip_n), .logic_array_block_clear_i(blk_clr),
        .logic_array_block_preset_i(blk_pre), .cascade_i(casc), .count_o(cnt),
        .config_done_i(cfg_done), .io_d_i(io_d), .io_clear_i(io_clr), .io_preset_i(io_pre),
        .io_q_o(io_q), .mem_local_clear_i(mem_lclr), .mem_global_clear_i(mem_gclr),
        .mem_in_d_i(mem_in), .mem_out_d_i(mem_out), .mem_in_q_o(mem_in_q),
        .mem_out_q_o(mem_out_q));

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    // one classic cycle; returns 1 ns after the ack edge so that edge's updates have landed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        `CHECK("bus ack", 1'h1, ack)
        rdat = dat_o;
        cyc <= 1'h0;
        #1;
    endtask : bus

    task automatic load(input logic [7:0] v);
        bus(1'h1, ADR_LOAD, {24'h0, v});
        bus(1'h1, ADR_CMD, C_SLD);
    endtask : load

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        bus(1'h0, ADR_CTRL, 32'h0);
        `CHECK("ctrl reset", {28'h0, CTRL_RST}, rdat)
        bus(1'h0, ADR_STATUS, 32'h0);
        `CHECK("unknown at power-up", 1'h1, rdat[STAT_UNK])
        `CHECK("count reset", PMASK, cnt)
        `CHECK("io before config", 1'h0, io_q)
        `CHECK("mem reset", 32'h0, {mem_in_q, mem_out_q})
        bus(1'h1, 8'h1c, 32'hffff_ffff);
        bus(1'h0, 8'h1c, 32'h0);
        `CHECK("unmapped read", 32'h0, rdat)
        $display("test reset done");
    endtask : t_reset

    task automatic t_sync;
        load(8'ha5);
        `CHECK("sync load", 8'ha5, cnt)
        bus(1'h1, ADR_CMD, C_SLD | C_CLR);
        `CHECK("clear beats load", 8'h00, cnt)
        bus(1'h1, ADR_CTRL, K_CNT | K_CAS | K_CHP);
        @(posedge clk_i);
        casc <= 8'h00;
        load(8'h5a);
        `CHECK("load over cascade", 8'h5a, cnt)
        // one edge with the chain low proves the cascade was really acting
        @(posedge clk_i);
        casc <= 8'hff;
        #1;
        `CHECK("cascade ands data", 8'h00, cnt)
        bus(1'h1, ADR_CMD, C_SLD);
        `CHECK("load with cascade open", 8'h5a, cnt)
        bus(1'h1, ADR_CMD, C_CLR);
        `CHECK("sync clear", 8'h00, cnt)
        bus(1'h1, ADR_CTRL, K_CNT | K_CHP);
        $display("test sync done");
    endtask : t_sync

    task automatic t_count;
        logic [7:0] v;
        load(8'hfd);
        bus(1'h1, ADR_CTRL, K_CNT | K_CHP | K_RUN);
        // crosses ff to 00 on the way
        for (int i = 0; i < 4; i++) begin
            v = cnt;
            @(posedge clk_i);
            #1;
            `CHECK("count step", v + 8'h1, cnt)
        end
        bus(1'h1, ADR_CTRL, K_CHP);
        bus(1'h1, ADR_ADDEND, 32'h3);
        bus(1'h1, ADR_CTRL, K_CHP | K_RUN);
        for (int i = 0; i < 3; i++) begin
            v = cnt;
            @(posedge clk_i);
            #1;
            `CHECK("arith step", v + 8'h3, cnt)
        end
        bus(1'h1, ADR_CTRL, K_CHP);
        v = cnt;
        bus(1'h0, ADR_COUNT, 32'h0);
        `CHECK("registered result", {24'h0, v}, rdat)
        bus(1'h0, ADR_COMB, 32'h0);
        `CHECK("unregistered result", v + 8'h3, rdat[7:0])
        bus(1'h1, ADR_CTRL, K_CNT | K_CHP);
        $display("test count done");
    endtask : t_count

    task automatic t_io;
        @(posedge clk_i);
        cfg_done <= 1'h1;
        @(posedge clk_i);
        #1;
        `CHECK("io after config", 1'h1, io_q)
        @(posedge clk_i);
        io_d <= 1'h0;
        @(posedge clk_i);
        io_pre <= 1'h1;
        #1;
        `CHECK("io preset refused", 1'h0, io_q)
        @(posedge clk_i);
        io_pre <= 1'h0;
        io_d <= 1'h1;
        @(posedge clk_i);
        io_clr <= 1'h1;
        #1;
        `CHECK("io async clear", 1'h0, io_q)
        @(posedge clk_i);
        io_clr <= 1'h0;
        @(posedge clk_i);
        #1;
        `CHECK("io data", 1'h1, io_q)
        $display("test io done");
    endtask : t_io

    task automatic t_mem;
        @(posedge clk_i);
        mem_in <= 16'h1234;
        mem_out <= 16'hc0de;
        @(posedge clk_i);
        mem_lclr <= 1'h1;
        #1;
        `CHECK("mem local clear", 32'h0, {mem_in_q, mem_out_q})
        @(posedge clk_i);
        mem_lclr <= 1'h0;
        @(posedge clk_i);
        #1;
        `CHECK("mem capture", 32'h1234_c0de, {mem_in_q, mem_out_q})
        @(posedge clk_i);
        mem_gclr <= 1'h1;
        #1;
        `CHECK("mem global clear", 32'h0, {mem_in_q, mem_out_q})
        @(posedge clk_i);
        mem_gclr <= 1'h0;
        $display("test mem done");
    endtask : t_mem

    task automatic t_async;
        load(8'hff);
        @(posedge clk_i);
        blk_clr <= 1'h1;
        #1;
        `CHECK("block clear", PMASK, cnt)
        bus(1'h1, ADR_CMD, C_SLD);
        `CHECK("clear beats load", PMASK, cnt)
        @(posedge clk_i);
        blk_clr <= 1'h0;
        load(8'h00);
        @(posedge clk_i);
        blk_pre <= 1'h1;
        #1;
        `CHECK("block preset", PMASK, cnt)
        @(posedge clk_i);
        blk_pre <= 1'h0;
        load(8'hf0);
        @(posedge clk_i);
        chip_n <= 1'h0;
        #1;
        `CHECK("chip reset cells", PMASK, cnt)
        `CHECK("chip reset io", 1'h0, io_q)
        bus(1'h1, ADR_CMD, C_SLD);
        `CHECK("chip reset wins", PMASK, cnt)
        `CHECK("chip reset mem", 32'h0, {mem_in_q, mem_out_q})
        @(posedge clk_i);
        chip_n <= 1'h1;
        bus(1'h0, ADR_STATUS, 32'h0);
        `CHECK("unknown set", 1'h1, rdat[STAT_UNK])
        load(8'h33);
        bus(1'h0, ADR_STATUS, 32'h0);
        `CHECK("unknown cleared", 1'h0, rdat[STAT_UNK])
        bus(1'h1, ADR_CTRL, K_CNT);
        @(posedge clk_i);
        chip_n <= 1'h0;
        #1;
        `CHECK("chip reset disabled", 8'h33, cnt)
        @(posedge clk_i);
        chip_n <= 1'h1;
        $display("test async done");
    endtask : t_async

    // ------------------------------------------------------------
    // sequence, watchdog and verdict
    // ------------------------------------------------------------
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset;
        t_sync;
        t_count;
        t_io;
        t_mem;
        t_async;
        close_out;
    end

    // the tests need well under 1000 cycles; 4000 means a hang
    initial begin
        #160000;
        $display("MISMATCH watchdog expected finish seen hang");
        error_cnt++;
        close_out;
    end
endmodule : lcrc_register_control_test
